// file: shared/dpr_cfg.svh
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH

// Clock period of core_clk_in
`define DPR_CLK_NS 40

// Memory geometry
`define DPR_ADDR_W 11
`define DPR_DATA_W 8

// Port timing, fastest grade, in ns
`define DPR_T_AS_NS 0
`define DPR_T_WC_NS 45
`define DPR_T_SW_NS 35
`define DPR_T_AW_NS 35
`define DPR_T_WP_NS 35
`define DPR_T_WR_NS 0
`define DPR_T_DW_NS 25
`define DPR_T_DH_NS 0
`define DPR_T_WZ_NS 20
`define DPR_T_HZ_NS 20
`define DPR_T_AA_NS 45
`define DPR_T_RC_NS 45
`define DPR_T_BAA_NS 35
`define DPR_T_BAC_NS 30
`define DPR_T_WDD_NS 70
`define DPR_T_DDD_NS 45
`define DPR_T_WH_NS 20

// Least time in whole cycles, never below one
`define DPR_CEIL(ns) (((ns) + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
`define DPR_CYC(ns) ((`DPR_CEIL(ns) > 0) ? `DPR_CEIL(ns) : 1)
`define DPR_MAX(a, b) (((a) > (b)) ? (a) : (b))

// Derived cycle counts, and the ns figure DPR_T_BDD_NS that DPR_C_BDD is made from
`define DPR_C_AS `DPR_CYC(`DPR_T_AS_NS)
`define DPR_C_WZ `DPR_CYC(`DPR_T_WZ_NS)
`define DPR_C_PULSE `DPR_MAX(`DPR_MAX(`DPR_CYC(`DPR_T_WP_NS), `DPR_CYC(`DPR_T_DW_NS)), \
   `DPR_MAX(`DPR_CYC(`DPR_T_SW_NS), `DPR_CYC(`DPR_T_AW_NS)))
`define DPR_C_WH `DPR_MAX(`DPR_CYC(`DPR_T_WH_NS), `DPR_C_PULSE)
`define DPR_C_DH `DPR_MAX(`DPR_CYC(`DPR_T_DH_NS), `DPR_CYC(`DPR_T_WR_NS))
`define DPR_C_ACC `DPR_MAX(`DPR_CYC(`DPR_T_AA_NS), `DPR_MAX(`DPR_CYC(`DPR_T_BAA_NS), `DPR_CYC(`DPR_T_BAC_NS)))
`define DPR_T_BDD_NS `DPR_MAX(0, `DPR_MAX(`DPR_T_WDD_NS - `DPR_T_WP_NS, `DPR_T_DDD_NS - `DPR_T_DW_NS))
`define DPR_C_BDD `DPR_CYC(`DPR_T_BDD_NS)
`define DPR_C_REC `DPR_MAX(`DPR_CYC(`DPR_T_HZ_NS), `DPR_CYC(`DPR_T_WC_NS - `DPR_T_SW_NS))

`define DPR_TMR_W 4

`endif

// file: shared/dpr_pkg.sv
package dpr_pkg;

   typedef enum logic [3:0] {
      DPR_IDLE,
      DPR_SETUP,
      DPR_WR_OFF,
      DPR_WR_PULSE,
      DPR_WR_BUSY,
      DPR_WR_HOLD,
      DPR_RD_ACC,
      DPR_RD_BUSY,
      DPR_RECOV
   } dpr_state_t;

endpackage

// file: shared/dpr_tmr_if.sv
`timescale 1ns/1ps
interface dpr_tmr_if #(parameter int W = 4);
   logic load;
   logic [W-1:0] value;
   logic done;

   modport ctl (output load, output value, input done);
   modport tmr (input load, input value, output done);
endinterface

// file: src/dpr_timer.sv
`timescale 1ns/1ps
module dpr_timer #(
   parameter int W = 4
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   dpr_tmr_if.tmr t
);
   import dpr_pkg::*;

   typedef struct packed {
      logic [W-1:0] cnt;
   } dpr_tmr_st_t;

   dpr_tmr_st_t s_q;
   dpr_tmr_st_t s_d;

   // Loading N of one or more makes the waiting state last exactly N cycles; loading 0 gives one cycle
   // Done looks only at the count, so load never feeds back into it
   assign t.done = (s_q.cnt <= W'(1));

   always_comb begin
      s_d = s_q;
      if (t.load) begin
         s_d.cnt = t.value;
      end else if (s_q.cnt != '0) begin
         s_d.cnt = s_q.cnt - W'(1);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         s_q <= '0;
      end else if (ce_in) begin
         s_q <= s_d;
      end
   end
endmodule // dpr_timer

// file: src/dpr_host.sv
`timescale 1ns/1ps
`include "dpr_cfg.svh"
module dpr_host #(
   parameter int AW = `DPR_ADDR_W,
   parameter int DW = `DPR_DATA_W
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic [DW-1:0] wdata_in,
   output logic ready_out,
   output logic done_out,
   output logic [DW-1:0] rdata_out,
   output logic contention_out,
   output dpr_pkg::dpr_state_t state_out,
   output logic cs_n_out,
   output logic rw_n_out,
   output logic oe_n_out,
   output logic [AW-1:0] mem_addr_out,
   output logic [DW-1:0] mem_data_out,
   output logic mem_data_oe_out,
   input wire logic [DW-1:0] mem_data_in,
   input wire logic busy_n_in
);
   import dpr_pkg::*;

   localparam int TW = `DPR_TMR_W;
   localparam logic [TW-1:0] C_AS = TW'(`DPR_C_AS);
   localparam logic [TW-1:0] C_WZ = TW'(`DPR_C_WZ);
   localparam logic [TW-1:0] C_PULSE = TW'(`DPR_C_PULSE);
   localparam logic [TW-1:0] C_WH = TW'(`DPR_C_WH);
   localparam logic [TW-1:0] C_DH = TW'(`DPR_C_DH);
   localparam logic [TW-1:0] C_ACC = TW'(`DPR_C_ACC);
   localparam logic [TW-1:0] C_BDD = TW'(`DPR_C_BDD);
   localparam logic [TW-1:0] C_REC = TW'(`DPR_C_REC);

   typedef struct packed {
      dpr_state_t st;
      logic cs_n;
      logic rw_n;
      logic oe_n;
      logic [AW-1:0] addr;
      logic [DW-1:0] dout;
      logic doe;
      logic [DW-1:0] rdata;
      logic done;
      logic cont;
      logic we;
      logic busy_seen;
   } dpr_host_st_t;

   dpr_host_st_t s_q;
   dpr_host_st_t s_d;

   dpr_tmr_if #(.W(TW)) tmr_bus ();

   dpr_timer #(
      .W(TW)
   ) u_timer (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .ce_in(ce_in),
      .t(tmr_bus.tmr)
   );

   assign ready_out = (s_q.st == DPR_IDLE);
   assign done_out = s_q.done;
   assign rdata_out = s_q.rdata;
   assign contention_out = s_q.cont;
   assign state_out = s_q.st;
   assign cs_n_out = s_q.cs_n;
   assign rw_n_out = s_q.rw_n;
   assign oe_n_out = s_q.oe_n;
   assign mem_addr_out = s_q.addr;
   assign mem_data_out = s_q.dout;
   assign mem_data_oe_out = s_q.doe;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.cont = 1'b0;
      tmr_bus.load = 1'b0;
      tmr_bus.value = '0;
      unique case (s_q.st)
         DPR_IDLE: begin
            // Address moves only with the port deselected and strobe high
            if (req_in) begin
               s_d.addr = addr_in;
               s_d.rw_n = 1'b1;
               s_d.cs_n = 1'b1;
               s_d.dout = wdata_in;
               s_d.we = we_in;
               s_d.busy_seen = 1'b0;
               tmr_bus.load = 1'b1;
               tmr_bus.value = C_AS;
               s_d.st = DPR_SETUP;
            end
         end
         DPR_SETUP: begin
            if (tmr_bus.done) begin
               // Address has been stable for a cycle before select falls
               s_d.cs_n = 1'b0;
               if (s_q.we) begin
                  // Select and strobe fall together, so the memory never turns its drivers on
                  s_d.rw_n = 1'b0;
                  // Output enable kept high during writes to avoid the longer pulse rule
                  s_d.oe_n = 1'b1;
                  tmr_bus.load = 1'b1;
                  tmr_bus.value = C_WZ;
                  s_d.st = DPR_WR_OFF;
               end else begin
                  s_d.rw_n = 1'b1;
                  s_d.oe_n = 1'b0;
                  tmr_bus.load = 1'b1;
                  tmr_bus.value = C_ACC;
                  s_d.st = DPR_RD_ACC;
               end
            end
         end
         DPR_WR_OFF: begin
            // Wait out the release time before putting data on the bus
            if (tmr_bus.done) begin
               s_d.doe = 1'b1;
               tmr_bus.load = 1'b1;
               tmr_bus.value = C_PULSE;
               s_d.st = DPR_WR_PULSE;
            end
         end
         DPR_WR_PULSE: begin
            if (!busy_n_in) begin
               // Flag low: a slave is inhibiting this write, keep it pending
               s_d.cont = 1'b1;
               s_d.busy_seen = 1'b1;
               s_d.st = DPR_WR_BUSY;
            end else if (tmr_bus.done) begin
               // Both go high together; data stays driven one more cycle
               s_d.cs_n = 1'b1;
               s_d.rw_n = 1'b1;
               tmr_bus.load = 1'b1;
               tmr_bus.value = C_DH;
               s_d.st = DPR_WR_HOLD;
            end
         end
         DPR_WR_BUSY: begin
            s_d.cont = 1'b1;
            if (busy_n_in) begin
               // Strobe held low past the flag release so the write lands
               tmr_bus.load = 1'b1;
               tmr_bus.value = C_WH;
               s_d.st = DPR_WR_PULSE;
            end
         end
         DPR_WR_HOLD: begin
            if (tmr_bus.done) begin
               s_d.doe = 1'b0;
               s_d.done = 1'b1;
               tmr_bus.load = 1'b1;
               tmr_bus.value = C_REC;
               s_d.st = DPR_RECOV;
            end
         end
         DPR_RD_ACC: begin
            // The access wait also covers the flag settling after a match
            if (tmr_bus.done) begin
               if (!busy_n_in) begin
                  s_d.cont = 1'b1;
                  s_d.busy_seen = 1'b1;
                  s_d.st = DPR_RD_BUSY;
               end else begin
                  s_d.rdata = mem_data_in;
                  s_d.cs_n = 1'b1;
                  s_d.oe_n = 1'b1;
                  s_d.done = 1'b1;
                  tmr_bus.load = 1'b1;
                  tmr_bus.value = C_REC;
                  s_d.st = DPR_RECOV;
               end
            end
         end
         DPR_RD_BUSY: begin
            s_d.cont = 1'b1;
            if (busy_n_in) begin
               // Worst-case delay since the writer's actual widths are unknown here
               tmr_bus.load = 1'b1;
               tmr_bus.value = C_BDD;
               s_d.st = DPR_RD_ACC;
            end
         end
         DPR_RECOV: begin
            // Gives the memory time to float the bus and pads the cycle time
            if (tmr_bus.done) begin
               s_d.st = DPR_IDLE;
            end
         end
         default: begin
            s_d.st = DPR_IDLE;
            s_d.cs_n = 1'b1;
            s_d.rw_n = 1'b1;
            s_d.oe_n = 1'b1;
            s_d.doe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         s_q.st <= DPR_IDLE;
         s_q.cs_n <= 1'b1;
         s_q.rw_n <= 1'b1;
         s_q.oe_n <= 1'b1;
         s_q.addr <= '0;
         s_q.dout <= '0;
         s_q.doe <= 1'b0;
         s_q.rdata <= '0;
         s_q.done <= 1'b0;
         s_q.cont <= 1'b0;
         s_q.we <= 1'b0;
         s_q.busy_seen <= 1'b0;
      end else if (ce_in) begin
         s_q <= s_d;
      end
   end
endmodule // dpr_host

// file: tb/dpr_host_sva.sv
`timescale 1ns/1ps
module dpr_host_sva #(
   parameter int AW = 11,
   parameter int DW = 8
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic ready_out,
   input wire logic done_out,
   input wire logic [DW-1:0] rdata_out,
   input wire logic contention_out,
   input wire logic cs_n_out,
   input wire logic rw_n_out,
   input wire logic oe_n_out,
   input wire logic [AW-1:0] mem_addr_out,
   input wire logic [DW-1:0] mem_data_out,
   input wire logic mem_data_oe_out,
   input wire logic [DW-1:0] mem_data_in,
   input wire logic busy_n_in
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   logic take;
   assign take = req_in && ready_out && ce_in;
   rd_strobe_hi_a: assert property (!oe_n_out |-> rw_n_out)
      else $error("strobe low while reading");
   addr_steady_a: assert property (!$stable(mem_addr_out) |-> cs_n_out && rw_n_out && $past(cs_n_out))
      else $error("address moved while selected");
   no_clash_a: assert property (mem_data_oe_out |-> oe_n_out)
      else $error("data driven with memory enabled");
   wr_end_data_a: assert property ($rose(rw_n_out) |-> $past(mem_data_oe_out) && mem_data_oe_out
      && $stable(mem_data_out))
      else $error("write data not held over write end");
   wr_pulse_a: assert property ($fell(rw_n_out) |-> $fell(cs_n_out) ##1 !(rw_n_out || cs_n_out))
      else $error("write pulse too short");
   sel_release_a: assert property ($rose(cs_n_out) && !$past(rw_n_out) |-> rw_n_out)
      else $error("select and strobe split");
   wr_answer_a: assert property (take && we_in ##1 busy_n_in [*4] |=> done_out)
      else $error("write answer late");
   rd_answer_a: assert property (take && !we_in ##1 busy_n_in [*3] |=> done_out)
      else $error("read answer late");
   rd_data_a: assert property (done_out && !$past(oe_n_out) |-> rdata_out == $past(mem_data_in))
      else $error("read data not captured");
   // Flag stays up for the one cycle after the wait state that saw the release
   busy_level_a: assert property (contention_out |-> !$past(busy_n_in)
      || ($past(contention_out) && !$past(busy_n_in, 2)))
      else $error("contention without flag");
   busy_hold_a: assert property (contention_out && !rw_n_out && $rose(busy_n_in) |=> !rw_n_out ##1 rw_n_out)
      else $error("write not held after flag release");
   cover property (take && we_in);
   cover property (take && !we_in);
   cover property (contention_out && !rw_n_out);
   cover property (contention_out && rw_n_out);
endmodule // dpr_host_sva
bind dpr_host dpr_host_sva #(.AW(AW), .DW(DW)) chk_u (.core_clk_in, .reset_in, .ce_in, .req_in, .we_in,
   .ready_out, .done_out, .rdata_out, .contention_out, .cs_n_out, .rw_n_out, .oe_n_out, .mem_addr_out,
   .mem_data_out, .mem_data_oe_out, .mem_data_in, .busy_n_in);

// file: tb/dpr_mem_model.sv
`timescale 1ns/1ps
module dpr_mem_model (
   input wire logic core_clk_in,
   input wire logic cs_n_in,
   input wire logic rw_n_in,
   input wire logic oe_n_in,
   input wire logic [10:0] addr_in,
   input wire logic [7:0] data_in,
   input wire logic data_oe_in,
   input wire logic peer_cs_n_in,
   input wire logic [10:0] peer_addr_in,
   output logic [7:0] data_out,
   output logic busy_n_out
);
   logic [7:0] mem [0:2047];
   logic [7:0] last_q;
   logic peer_first_q;
   logic drive;
   initial begin
      for (int i = 0; i < 2048; i++) mem[i] = 8'(i) ^ 8'h5a;
      last_q = 8'h00;
      peer_first_q = 1'b0;
   end
   // Combinational flag, well inside the 30 and 35 ns limits
   assign busy_n_out = !(peer_first_q && !peer_cs_n_in && !cs_n_in && peer_addr_in == addr_in);
   assign drive = !cs_n_in && rw_n_in && !oe_n_in;
   // Released pins show the inverse of the last value, never a stale copy
   assign data_out = drive ? mem[addr_in] : ~last_q;
   always @(posedge core_clk_in) begin
      peer_first_q <= !peer_cs_n_in && (peer_first_q || cs_n_in);
      last_q <= data_out;
      if (!cs_n_in && !rw_n_in && data_oe_in && busy_n_out) mem[addr_in] <= data_in;
   end
endmodule // dpr_mem_model

// file: tb/dual_port_ram_access_arbitration_tb.sv
`timescale 1ns/1ps
module dual_port_ram_access_arbitration_tb;
   typedef struct {logic w; logic [10:0] a; logic [7:0] d;} dpr_row_t;
   logic clk, rst, ce, req, we, ready, done, cont, cs_n, rw_n, oe_n, doe, busy_n, pcs_n;
   dpr_pkg::dpr_state_t st;
   logic [10:0] addr, maddr, paddr;
   logic [7:0] wd, rd, dout, din, mout;
   int err_total, checked, lat, seen;
   dpr_row_t rows [7] = '{'{1'b1, 11'h000, 8'ha5}, '{1'b1, 11'h7ff, 8'h3c}, '{1'b0, 11'h000, 8'ha5},
      '{1'b0, 11'h7ff, 8'h3c}, '{1'b0, 11'h123, 8'h79}, '{1'b1, 11'h123, 8'hff}, '{1'b0, 11'h123, 8'hff}};
   dpr_host dut_u (.core_clk_in(clk), .reset_in(rst), .ce_in(ce), .req_in(req), .we_in(we), .addr_in(addr),
      .wdata_in(wd), .ready_out(ready), .done_out(done), .rdata_out(rd), .contention_out(cont), .state_out(st),
      .cs_n_out(cs_n), .rw_n_out(rw_n), .oe_n_out(oe_n), .mem_addr_out(maddr), .mem_data_out(dout),
      .mem_data_oe_out(doe), .mem_data_in(din), .busy_n_in(busy_n));
   dpr_mem_model mem_u (.core_clk_in(clk), .cs_n_in(cs_n), .rw_n_in(rw_n), .oe_n_in(oe_n), .addr_in(maddr),
      .data_in(din), .data_oe_in(doe), .peer_cs_n_in(pcs_n), .peer_addr_in(paddr), .data_out(mout),
      .busy_n_out(busy_n));
   assign din = doe ? dout : mout;
   task automatic tally_and_finish;
      if (err_total == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d);
      lat = 0;
      seen = 0;
      while (ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      req <= 1'b1;
      we <= w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      req <= 1'b0;
      while (done !== 1'b1 && lat < 60) begin
         @(negedge clk);
         lat++;
         if (cont === 1'b1) seen = 1;
      end
   endtask
   // Contended access: peer holds the same address first, then lets go
   task automatic contend(input logic w, input logic [10:0] a, input logic [7:0] d, input logic [7:0] old);
      @(posedge clk);
      pcs_n <= 1'b0;
      paddr <= a;
      fork
         xfer(w, a, d);
         begin
            repeat (8) @(negedge clk);
            chk("blocked", mem_u.mem[a], old);
            @(posedge clk);
            pcs_n <= 1'b1;
         end
      join
      chk("busy seen", 16'(seen), 16'h0001);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (2000) @(posedge clk);
      err_total++;
      tally_and_finish();
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      req = 1'b0;
      we = 1'b0;
      addr = 11'h000;
      wd = 8'h00;
      pcs_n = 1'b1;
      paddr = 11'h000;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("idle pins", {cs_n, rw_n, oe_n, doe, ready, done, cont}, 7'h74);
      chk("idle state", 16'(st), 16'(dpr_pkg::DPR_IDLE));
      foreach (rows[i]) begin
         xfer(rows[i].w, rows[i].a, rows[i].d);
         chk("latency", 16'(lat), rows[i].w ? 16'h0005 : 16'h0004);
         if (!rows[i].w) chk("rdata", rd, rows[i].d);
      end
      contend(1'b1, 11'h055, 8'h96, 8'h0f);
      xfer(1'b0, 11'h055, 8'h00);
      chk("rdata after busy", rd, 8'h96);
      contend(1'b0, 11'h0aa, 8'h00, 8'hf0);
      chk("busy read", rd, 8'hf0);
      // Request held while the clock enable is low must not be taken
      @(posedge clk);
      ce <= 1'b0;
      req <= 1'b1;
      we <= 1'b0;
      addr <= 11'h123;
      repeat (3) @(negedge clk);
      chk("frozen", {ready, cs_n, oe_n}, 3'h7);
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      repeat (4) @(negedge clk);
      chk("read after freeze", {done, rd}, {1'b1, 8'hff});
      // Reset in the middle of a write leaves the location untouched
      @(posedge clk);
      req <= 1'b1;
      we <= 1'b1;
      addr <= 11'h200;
      wd <= 8'h11;
      @(posedge clk);
      req <= 1'b0;
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("reset pins", {cs_n, rw_n, oe_n, doe, ready, done, cont}, 7'h74);
      chk("aborted write", mem_u.mem[11'h200], 8'h5a);
      xfer(1'b0, 11'h200, 8'h00);
      chk("rdata after reset", rd, 8'h5a);
      tally_and_finish();
   end
endmodule // dual_port_ram_access_arbitration_tb
